// >>> rtl/ata_cmd_pkg.sv
/*
  constants for the ata command and identify unit: register map, opcodes,
  subcommands, identify words and status codes.
  assumes a single 10 MHz clock and an avalon-mm master with waitrequest.
*/
package ata_cmd_pkg;
  localparam int ADDR_W = 4;
  // register word indices (byte address = index * 4)
  localparam logic [ADDR_W-1:0] REG_CMD = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h1;
  localparam logic [ADDR_W-1:0] REG_FEATURES = 4'h2;
  localparam logic [ADDR_W-1:0] REG_ID_ADDR = 4'h3;
  localparam logic [ADDR_W-1:0] REG_ID_DATA = 4'h4;
  localparam logic [ADDR_W-1:0] REG_SERIAL = 4'h5;
  localparam logic [ADDR_W-1:0] REG_FWREV = 4'h6;
  localparam logic [ADDR_W-1:0] REG_POWER = 4'h7;

  // command register fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_FEAT_LSB = 8;
  localparam int CMD_SEL_LSB = 16;

  // status register bits
  localparam int ST_DONE = 0;
  localparam int ST_ABORT = 1;
  localparam int ST_ID_READY = 2;
  localparam int ST_CLASS_LSB = 4;
  localparam int ST_OP_LSB = 8;

  // feature register bits
  localparam int F_WCACHE = 0;
  localparam int F_APM = 1;
  localparam int F_REVERT = 2;
  localparam int F_SATA_LSB = 3;
  localparam int SATA_FEAT_N = 5;

  // power register bits
  localparam int P_SLEEP_PIN = 0;
  localparam int P_LOW_POWER = 1;

  localparam logic [31:0] RESET_FEATURES = 32'h0000_0005;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  // opcodes
  localparam logic [7:0] OP_READ_DMA = 8'hC8;
  localparam logic [7:0] OP_READ_DMA_NR = 8'hC9;
  localparam logic [7:0] OP_WRITE_DMA_FUA = 8'h3D;
  localparam logic [7:0] OP_READ_NMAX = 8'h27;
  localparam logic [7:0] OP_HEALTH = 8'hB0;
  localparam logic [7:0] OP_SET_MAX = 8'hF9;
  localparam logic [7:0] OP_IDENTIFY = 8'hEC;
  localparam logic [7:0] OP_SET_FEAT = 8'hEF;

  // set-features subcodes
  localparam logic [7:0] SF_WCACHE_ON = 8'h02;
  localparam logic [7:0] SF_XFER_MODE = 8'h03;
  localparam logic [7:0] SF_APM_ON = 8'h05;
  localparam logic [7:0] SF_SATA_ON = 8'h10;
  localparam logic [7:0] SF_LOOKAHEAD_OFF = 8'h55;
  localparam logic [7:0] SF_REVERT_OFF = 8'h66;
  localparam logic [7:0] SF_WCACHE_OFF = 8'h82;
  localparam logic [7:0] SF_APM_OFF = 8'h85;
  localparam logic [7:0] SF_SATA_OFF = 8'h90;
  localparam logic [7:0] SF_LOOKAHEAD_ON = 8'hAA;
  localparam logic [7:0] SF_REVERT_ON = 8'hCC;

  // sata feature selectors, in feature-bit order
  localparam logic [7:0] SEL_DMA_AUTO = 8'h02;
  localparam logic [7:0] SEL_DIPM = 8'h03;
  localparam logic [7:0] SEL_SSP = 8'h06;
  localparam logic [7:0] SEL_AUTO_SLUMBER = 8'h07;
  localparam logic [7:0] SEL_DEVSLP = 8'h09;

  // health subcommands
  localparam logic [7:0] HM_FIRST = 8'hD0;
  localparam logic [7:0] HM_LAST = 8'hDB;
  localparam logic [7:0] HM_HOLE = 8'hD7;
  // set-max subcommands
  localparam logic [7:0] SM_FIRST = 8'h01;
  localparam logic [7:0] SM_LAST = 8'h04;

  // command class reported in status
  typedef enum logic [3:0] {
    CLS_NONE = 4'h0,
    CLS_DMA_READ = 4'h1,
    CLS_DMA_WRITE_FUA = 4'h2,
    CLS_NATIVE_MAX = 4'h3,
    CLS_HEALTH = 4'h4,
    CLS_SET_MAX = 4'h5,
    CLS_IDENTIFY = 4'h6,
    CLS_SET_FEAT = 4'h7,
    CLS_OTHER = 4'h8
  } cmd_class_e;

  // identify sector
  localparam int ID_WORDS = 256;
  localparam int ID_AW = 8;
  localparam int SERIAL_FIRST = 10;
  localparam int SERIAL_LAST = 19;
  localparam int FWREV_FIRST = 23;
  localparam int FWREV_LAST = 26;
  localparam logic [15:0] ID_W47 = 16'h8010;
  localparam logic [15:0] ID_W48 = 16'h4000;
  localparam logic [15:0] ID_W53 = 16'h0007;
  localparam logic [15:0] ID_W59 = 16'h5D10;
  localparam logic [15:0] ID_W63 = 16'h0407;
  localparam logic [15:0] ID_CYCLE = 16'h0078;
  localparam logic [15:0] ID_W69 = 16'h1D00;
  localparam logic [15:0] ID_W93 = 16'h0000;
  localparam logic [15:0] ID_ZERO = 16'h0000;
endpackage

// >>> rtl/ata_command_and_identify_unit.sv
/*
  ata command decoder, set-features state and identify sector source,
  reached over an avalon-mm slave with waitrequest.
  assumes one 10 MHz clock, synchronous reset and an asynchronous
  device-sleep pin that is synchronised here.
*/
// Implementation choices: the placing of the registers and the Avalon-MM register port.
// What this block does
// [RL1] sleep pin high requests low power state
// [RL2] identify opcode yields 256-word identification sector
// [RL3] word 47 reads fixed 8010h
// [RL4] word 59 reads fixed 5D10h
// [RL5] word 53 reads fixed 0007h
// [RL6] word 63 reads fixed 0407h
// [RL7] words 65 and 66 read 0078h
// [RL8] words 67 and 68 read 0078h
// [RL9] word 69 reads fixed 1D00h
// [RL10] word 48 reads fixed 4000h
// [RL11] words 10 to 19 hold serial number
// [RL12] words 23 to 26 hold firmware revision
// [RL13] sata selectors 02h, 06h switch auto-activate, preservation
// [RL14] sata selectors 03h, 07h, 09h switch power features
// [RL15] subcodes 02h/82h switch write cache
// [RL16] subcodes 05h/85h switch power management
// [RL17] subcodes 66h/CCh switch reverting to defaults
// [RL18] health opcode decodes subcommands D0h to DBh, less D7h
// [RL19] set-max accepts subcommands 01h to 04h
// [RL20] C9h handled as ordinary dma read
// [RL21] 3Dh accepted as forced-unit-access dma write
// [RL22] 27h returns native maximum address; here 27h only completes with class CLS_NATIVE_MAX and no address is returned
// [RL23] unsupported opcode or subcommand completes aborted
// [RL24] word 93 reads zero
`timescale 1ns/100ps
module ata_command_and_identify_unit #(
  parameter logic [159:0] SERIAL_TEXT = {20{8'h30}},
  parameter logic [63:0] FWREV_TEXT = {8{8'h31}}
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [ata_cmd_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic dev_sleep,
  output logic low_power,
  output logic cmd_done,
  output logic cmd_abort,
  output logic [3:0] cmd_class
);
  import ata_cmd_pkg::*;

  logic [2:0] sleep_sync;
  logic sleep_level;
  logic [31:0] features;
  logic [7:0] id_addr;
  logic [15:0] id_word;
  logic id_ready;
  logic [7:0] last_op;
  logic [31:0] serial_sel;
  logic [31:0] fwrev_sel;
  logic ack;

  // true when a subcommand lies inside the health range, less the hole
  function automatic logic health_ok(input logic [7:0] sub);
    health_ok = (sub >= HM_FIRST) && (sub <= HM_LAST) && (sub != HM_HOLE);
  endfunction

  // maps a sata selector to its feature bit, or none
  function automatic logic [SATA_FEAT_N-1:0] sata_bit(input logic [7:0] sel);
    unique case (sel)
      SEL_DMA_AUTO: sata_bit = 5'h01;
      SEL_DIPM: sata_bit = 5'h02;
      SEL_SSP: sata_bit = 5'h04;
      SEL_AUTO_SLUMBER: sata_bit = 5'h08;
      SEL_DEVSLP: sata_bit = 5'h10;
      default: sata_bit = 5'h00;
    endcase
  endfunction

  // identify word table
  function automatic logic [15:0] id_lookup(input logic [7:0] w);
    int i;
    i = int'(w);
    id_lookup = ID_ZERO;
    if (i >= SERIAL_FIRST && i <= SERIAL_LAST) begin
      id_lookup = SERIAL_TEXT[159 - 16*(i-SERIAL_FIRST) -: 16]; // [RL11]
    end else if (i >= FWREV_FIRST && i <= FWREV_LAST) begin
      id_lookup = FWREV_TEXT[63 - 16*(i-FWREV_FIRST) -: 16]; // [RL12]
    end else begin
      unique case (i)
        47: id_lookup = ID_W47; // [RL3]
        48: id_lookup = ID_W48; // [RL10]
        53: id_lookup = ID_W53; // [RL5]
        59: id_lookup = ID_W59; // [RL4]
        63: id_lookup = ID_W63; // [RL6]
        65, 66: id_lookup = ID_CYCLE; // [RL7]
        67, 68: id_lookup = ID_CYCLE; // [RL8]
        69: id_lookup = ID_W69; // [RL9]
        93: id_lookup = ID_W93; // [RL24]
        default: id_lookup = ID_ZERO;
      endcase
    end
  endfunction

  // command decode
  logic [7:0] c_op;
  logic [7:0] c_feat;
  logic [7:0] c_sel;
  logic c_ok;
  cmd_class_e c_cls;
  logic cmd_wr;
  assign c_op = writedata[CMD_OP_LSB +: 8];
  assign c_feat = writedata[CMD_FEAT_LSB +: 8];
  assign c_sel = writedata[CMD_SEL_LSB +: 8];
  assign cmd_wr = write && ack && address == REG_CMD;

  always_comb begin
    c_ok = 1'b0;
    c_cls = CLS_OTHER;
    unique case (c_op)
      OP_READ_DMA, OP_READ_DMA_NR: begin
        c_ok = 1'b1; // [RL20]
        c_cls = CLS_DMA_READ;
      end
      OP_WRITE_DMA_FUA: begin
        c_ok = 1'b1; // [RL21]
        c_cls = CLS_DMA_WRITE_FUA;
      end
      OP_READ_NMAX: begin
        c_ok = 1'b1; // [RL22]
        c_cls = CLS_NATIVE_MAX;
      end
      OP_HEALTH: begin
        c_ok = health_ok(c_feat); // [RL18]
        c_cls = CLS_HEALTH;
      end
      OP_SET_MAX: begin
        c_ok = (c_feat >= SM_FIRST) && (c_feat <= SM_LAST); // [RL19]
        c_cls = CLS_SET_MAX;
      end
      OP_IDENTIFY: begin
        c_ok = 1'b1; // [RL2]
        c_cls = CLS_IDENTIFY;
      end
      OP_SET_FEAT: begin
        c_cls = CLS_SET_FEAT;
        unique case (c_feat)
          SF_WCACHE_ON, SF_WCACHE_OFF, SF_APM_ON, SF_APM_OFF,
          SF_REVERT_OFF, SF_REVERT_ON, SF_XFER_MODE,
          SF_LOOKAHEAD_ON, SF_LOOKAHEAD_OFF: c_ok = 1'b1;
          SF_SATA_ON, SF_SATA_OFF: c_ok = sata_bit(c_sel) != '0;
          default: c_ok = 1'b0;
        endcase
      end
      default: begin
        c_ok = 1'b0; // [RL23]
        c_cls = CLS_NONE;
      end
    endcase
  end

  // bus: one wait cycle on every access, answered in the next
  always_ff @(posedge mclk) begin
    if (rst) begin
      ack <= 1'b0;
    end else begin
      ack <= (read || write) && !ack;
    end
  end
  assign waitrequest = (read || write) && !ack;

  // completion status of the last command
  always_ff @(posedge mclk) begin
    if (rst) begin
      cmd_done <= 1'b0;
      cmd_abort <= 1'b0;
      cmd_class <= CLS_NONE;
      last_op <= 8'h00;
    end else if (cmd_wr) begin
      cmd_done <= 1'b1;
      cmd_abort <= !c_ok; // [RL23]
      cmd_class <= c_cls;
      last_op <= c_op;
    end
  end

  // set-features state, written only by accepted commands
  always_ff @(posedge mclk) begin
    if (rst) begin
      features <= RESET_FEATURES;
    end else if (cmd_wr && c_ok && c_op == OP_SET_FEAT) begin
      unique case (c_feat)
        SF_WCACHE_ON: features[F_WCACHE] <= 1'b1; // [RL15]
        SF_WCACHE_OFF: features[F_WCACHE] <= 1'b0; // [RL15]
        SF_APM_ON: features[F_APM] <= 1'b1; // [RL16]
        SF_APM_OFF: features[F_APM] <= 1'b0; // [RL16]
        SF_REVERT_OFF: features[F_REVERT] <= 1'b0; // [RL17]
        SF_REVERT_ON: features[F_REVERT] <= 1'b1; // [RL17]
        SF_SATA_ON: features[F_SATA_LSB +: SATA_FEAT_N] <=
          features[F_SATA_LSB +: SATA_FEAT_N] | sata_bit(c_sel); // [RL13] [RL14]
        SF_SATA_OFF: features[F_SATA_LSB +: SATA_FEAT_N] <=
          features[F_SATA_LSB +: SATA_FEAT_N] & ~sata_bit(c_sel); // [RL13] [RL14]
        default: features <= features;
      endcase
    end
  end

  // identify sector pointer; an identify command rewinds it
  always_ff @(posedge mclk) begin
    if (rst) begin
      id_addr <= 8'h00;
      id_ready <= 1'b0;
    end else if (cmd_wr && c_op == OP_IDENTIFY) begin
      id_addr <= 8'h00; // [RL2]
      id_ready <= 1'b1;
    end else if (write && ack && address == REG_ID_ADDR) begin
      id_addr <= writedata[ID_AW-1:0];
    end else if (read && ack && address == REG_ID_DATA && id_ready) begin
      id_addr <= id_addr + 8'h01;
      if (id_addr == 8'(ID_WORDS-1)) begin
        id_ready <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      id_word <= ID_ZERO;
    end else begin
      id_word <= id_lookup(id_addr);
    end
  end

  // device-sleep pin: three stages, change counts when last two agree
  always_ff @(posedge mclk) begin
    if (rst) begin
      sleep_sync <= 3'h0;
      sleep_level <= 1'b0;
    end else begin
      sleep_sync <= {sleep_sync[1:0], dev_sleep};
      if (sleep_sync[2] == sleep_sync[1]) begin
        sleep_level <= sleep_sync[1];
      end
    end
  end

  // low power follows the pin when device sleep is enabled
  always_ff @(posedge mclk) begin
    if (rst) begin
      low_power <= 1'b0;
    end else begin
      low_power <= sleep_level && features[F_SATA_LSB + SATA_FEAT_N - 1]; // [RL1]
    end
  end

  assign serial_sel = {24'h000000, 8'(id_addr)};
  assign fwrev_sel = 32'h0000_0000;

  // read data
  always_ff @(posedge mclk) begin
    if (rst) begin
      readdata <= UNMAPPED_READ;
    end else if (read && !ack) begin
      unique case (address)
        REG_CMD: readdata <= {24'h000000, last_op};
        REG_STATUS: readdata <= {16'h0000, last_op, cmd_class,
          1'b0, id_ready, cmd_abort, cmd_done};
        REG_FEATURES: readdata <= features;
        REG_ID_ADDR: readdata <= serial_sel;
        REG_ID_DATA: readdata <= {16'h0000, id_lookup(id_addr)};
        REG_SERIAL: readdata <= {16'h0000, id_word};
        REG_FWREV: readdata <= fwrev_sel;
        REG_POWER: readdata <= {30'h0, low_power, sleep_level};
        default: readdata <= UNMAPPED_READ;
      endcase
    end
  end
endmodule

// >>> sim/ata_cmd_chk.sv
/*
  port assertions for the command and identify unit.
  assumes one clock mclk and synchronous active-high reset rst.
*/
`timescale 1ns/100ps
module ata_cmd_chk
  import ata_cmd_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [ata_cmd_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic dev_sleep,
  input wire logic low_power,
  input wire logic cmd_done,
  input wire logic cmd_abort,
  input wire logic [3:0] cmd_class
);
  logic cmd_acc;
  assign cmd_acc = write && !waitrequest && address == REG_CMD;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  AST_WAIT_ONE: assert property ($rose(read || write) |-> waitrequest ##1 !waitrequest)
    else $error("request not answered after one wait cycle");
  AST_IDLE_NOWAIT: assert property (!read && !write |-> !waitrequest)
    else $error("wait raised while idle");
  AST_SLEEP_OFF: assert property (!dev_sleep [*6] |-> !low_power)
    else $error("low power without sleep pin");
  AST_ABORT_DONE: assert property (cmd_abort |-> cmd_done)
    else $error("abort without completion");
  AST_HOLD: assert property (!cmd_acc && !$past(cmd_acc) |=> $stable({cmd_done, cmd_abort, cmd_class}))
    else $error("status changed without command");
  AST_NO_ABORT: assert property (cmd_class inside {CLS_DMA_READ, CLS_DMA_WRITE_FUA,
      CLS_NATIVE_MAX, CLS_IDENTIFY} |-> !cmd_abort)
    else $error("plain command aborted");
  AST_LP_DONE: assert property (low_power |-> cmd_done)
    else $error("low power before feature enabled");
  AST_UNMAPPED: assert property (read && !waitrequest && address[3] |-> readdata == UNMAPPED_READ)
    else $error("unmapped read not zero");
  cover property (low_power);
  cover property (cmd_abort);
  cover property (cmd_class == CLS_IDENTIFY);
endmodule

// >>> sim/host_sleep_model.sv
/*
  host-side model of the device-sleep pin.
  assumes the bench asks for sleep on mclk edges.
*/
`timescale 1ns/100ps
module host_sleep_model (
  input wire logic mclk,
  input wire logic sleep_req,
  output logic dev_sleep
);
  // pin driven high asks the device for low power
  always_ff @(posedge mclk) begin
    dev_sleep <= sleep_req;
  end
endmodule

// >>> sim/ata_command_and_identify_unit_bench.sv
/*
  bench for the command and identify unit: avalon tasks, identify dump,
  feature, decode and sleep sequences. assumes a 10 MHz mclk.
*/
`timescale 1ns/100ps
module ata_command_and_identify_unit_bench;
  import ata_cmd_pkg::*;
  logic mclk = 0, rst = 1, read = 0, write = 0, sleep_req = 0;
  logic [ADDR_W-1:0] address = '0;
  logic [31:0] writedata = '0, readdata, rd_val, feat;
  logic waitrequest, dev_sleep, low_power, cmd_done, cmd_abort;
  logic [3:0] cmd_class;
  logic [16:0] e;
  logic [7:0] sel [5] = '{8'h02, 8'h03, 8'h06, 8'h07, 8'h09};
  int miscompares = 0, checks = 0, cycles = 0;
  ata_command_and_identify_unit #(.SERIAL_TEXT({20{8'h53}}), .FWREV_TEXT({8{8'h46}})) u_dut (
    .mclk(mclk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
    .dev_sleep(dev_sleep), .low_power(low_power), .cmd_done(cmd_done),
    .cmd_abort(cmd_abort), .cmd_class(cmd_class));
  host_sleep_model u_host (.mclk(mclk), .sleep_req(sleep_req), .dev_sleep(dev_sleep));
  initial forever #50 mclk = ~mclk;
  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic xfer(input logic [3:0] a, input logic wr, input logic [31:0] d);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    @(posedge mclk);
    while (waitrequest !== 1'b0) @(posedge mclk);
    rd_val = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [7:0] f, input logic [7:0] s,
                     input logic ab, input logic [3:0] cl);
    xfer(REG_CMD, 1, {8'h00, s, f, op});
    xfer(REG_STATUS, 0, 0);
    chk("cmd_abort", {31'h0, ab}, {31'h0, cmd_abort});
    if (ab) begin
      chk("abort", 32'h3, rd_val & 32'h3);
    end else begin
      chk("status", {16'h0, op, cl, 4'h1}, rd_val & 32'h0000_FFF3);
      chk("cmd_class", {28'h0, cl}, {28'h0, cmd_class});
    end
  endtask
  task automatic sf(input logic [7:0] sub, input logic [7:0] s, input int b, input logic on);
    cmd(8'hEF, sub, s, 0, CLS_SET_FEAT);
    feat[b] = on;
    xfer(REG_FEATURES, 0, 0);
    chk("features", feat, rd_val);
  endtask
  task automatic wait_lp(input logic v);
    for (int n = 0; n < 20 && low_power !== v; n++) @(posedge mclk);
    chk("low_power", {31'h0, v}, {31'h0, low_power});
    @(posedge mclk);
  endtask
  function automatic logic [16:0] idw(input int w);
    case (w)
      47: return 17'h18010;
      48: return 17'h14000;
      53: return 17'h10007;
      59: return 17'h15D10;
      63: return 17'h10407;
      65, 66, 67, 68: return 17'h10078;
      69: return 17'h11D00;
      93: return 17'h10000;
      default: return (w >= 10 && w <= 19) ? 17'h15353 : (w >= 23 && w <= 26) ? 17'h14646 : 17'h0;
    endcase
  endfunction
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 0;
    feat = 32'h5;
    xfer(REG_FEATURES, 0, 0);
    chk("features", feat, rd_val);
    cmd(8'hEC, 0, 0, 0, CLS_IDENTIFY);
    for (int i = 0; i < 256; i++) begin
      xfer(REG_ID_DATA, 0, 0);
      e = idw(i);
      if (e[16]) chk("id_word", {16'h0, e[15:0]}, rd_val & 32'hFFFF);
    end
    xfer(REG_ID_ADDR, 1, 32'h0000_002F);
    xfer(REG_ID_ADDR, 0, 0);
    chk("id_addr", 32'h0000_002F, rd_val);
    xfer(REG_SERIAL, 0, 0);
    chk("id_copy", 32'h0000_8010, rd_val);
    sf(8'h82, 0, 0, 0);
    sf(8'h02, 0, 0, 1);
    sf(8'h05, 0, 1, 1);
    sf(8'h85, 0, 1, 0);
    sf(8'h66, 0, 2, 0);
    sf(8'hCC, 0, 2, 1);
    foreach (sel[k]) sf(8'h10, sel[k], 3 + k, 1);
    foreach (sel[k]) sf(8'h90, sel[k], 3 + k, 0);
    sf(8'h10, 8'h09, 7, 1);
    cmd(8'hC8, 0, 0, 0, CLS_DMA_READ);
    cmd(8'hC9, 0, 0, 0, CLS_DMA_READ);
    cmd(8'h3D, 0, 0, 0, CLS_DMA_WRITE_FUA);
    cmd(8'h27, 0, 0, 0, CLS_NATIVE_MAX);
    for (int s = 8'hD0; s <= 8'hDB; s++) cmd(8'hB0, s[7:0], 0, s == 8'hD7, CLS_HEALTH);
    for (int s = 0; s < 6; s++) cmd(8'hF9, s[7:0], 0, s < 1 || s > 4, CLS_SET_MAX);
    cmd(8'h00, 0, 0, 1, 0);
    cmd(8'hEF, 8'h10, 8'h05, 1, 0);
    xfer(REG_FEATURES, 0, 0);
    chk("features", feat, rd_val);
    xfer(4'h9, 1, 32'hFFFF_FFFF);
    xfer(4'h9, 0, 0);
    chk("unmapped", 32'h0, rd_val);
    sleep_req <= 1;
    wait_lp(1);
    xfer(REG_POWER, 0, 0);
    chk("power", 32'h3, rd_val);
    sleep_req <= 0;
    wait_lp(0);
    xfer(REG_POWER, 0, 0);
    chk("power", 32'h0, rd_val);
    sleep_req <= 1;
    wait_lp(1);
    sf(8'h90, 8'h09, 7, 0);
    wait_lp(0);
    xfer(REG_POWER, 0, 0);
    chk("power", 32'h1, rd_val);
    sleep_req <= 0;
    stop_test();
  end
endmodule
bind ata_command_and_identify_unit ata_cmd_chk u_chk (.mclk(mclk), .rst(rst),
  .address(address), .read(read), .write(write), .readdata(readdata),
  .waitrequest(waitrequest), .dev_sleep(dev_sleep), .low_power(low_power),
  .cmd_done(cmd_done), .cmd_abort(cmd_abort), .cmd_class(cmd_class));
